// ### hw/sdrba_device.sv
// Device-side bank, row and burst access logic with a Wishbone register slave.
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module sdrba_device (
    input wire logic clock,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire sdrba_pkg::sdrba_pins_t cmd_pins,
    input wire logic [15:0] dq_in,
    input wire logic dqs_in,
    output logic [15:0] dq_out,
    output logic dq_oe_n,
    output logic dqs_out,
    output logic dqs_oe_n
);
    function automatic logic is_cmd(input sdrba_pkg::sdrba_pins_t p,
                                    input sdrba_pkg::sdrba_cmd_t c);
        is_cmd = !p.cs_n && ({p.ras_n, p.cas_n, p.we_n} == c);
    endfunction : is_cmd

    function automatic logic [6:0] burst_idx(input logic [2:0] bank, input logic row0,
            input logic [2:0] col, input logic [3:0] beat, input logic chop);
        logic [2:0] c;
        // A chopped burst wraps inside its own half of the eight-word block.
        c = chop ? {col[2], col[1:0] + beat[1:0]} : col + beat[2:0];
        burst_idx = {bank, row0, c};
    endfunction : burst_idx

    sdrba_pkg::sdrba_pins_t pins_m, pins_s;
    logic [15:0] dq_m, dq_s;
    logic dqs_m, dqs_s;

    // Pins are asynchronous to this clock, so every one passes two flip-flops.
    always_ff @(posedge clock) begin
        if (reset) begin
            pins_m <= '1;
            pins_s <= '1;
            dq_m <= 16'h0000;
            dq_s <= 16'h0000;
            dqs_m <= 1'b0;
            dqs_s <= 1'b0;
        end else begin
            pins_m <= cmd_pins;
            pins_s <= pins_m;
            dq_m <= dq_in;
            dq_s <= dq_m;
            dqs_m <= dqs_in;
            dqs_s <= dqs_m;
        end
    end

    logic act_cmd, pre_cmd, rd_cmd, wr_cmd, col_cmd;
    logic [2:0] cmd_bank;
    logic [15:0] cmd_addr;
    assign act_cmd = is_cmd(pins_s, sdrba_pkg::CMD_ACT);
    assign pre_cmd = is_cmd(pins_s, sdrba_pkg::CMD_PRE);
    assign rd_cmd = is_cmd(pins_s, sdrba_pkg::CMD_READ);
    assign wr_cmd = is_cmd(pins_s, sdrba_pkg::CMD_WRITE);
    assign col_cmd = rd_cmd || wr_cmd;
    assign cmd_bank = pins_s.bank_select_inputs;
    assign cmd_addr = pins_s.row_address_inputs;

    logic [7:0] ctrl;
    logic [sdrba_pkg::ERR_BITS-1:0] err, err_set, err_clr;
    logic [3:0] cl;
    logic [4:0] rl;
    logic bl_otf, cmd_chop;
    assign cl = (ctrl[sdrba_pkg::CTRL_CL_LSB +: 4] < sdrba_pkg::CL_MIN) ?
        sdrba_pkg::CL_MIN : ctrl[sdrba_pkg::CTRL_CL_LSB +: 4];
    assign rl = {1'b0, cl} + (ctrl[sdrba_pkg::CTRL_AL_BIT] ? {1'b0, cl} - 5'h01 : 5'h00);
    assign bl_otf = ctrl[1:0] == sdrba_pkg::BL_FIXED8 || ctrl[1:0] == sdrba_pkg::BL_OTF;
    assign cmd_chop = bl_otf ? !cmd_addr[sdrba_pkg::BURST_SEL_BIT] :
        ctrl[1:0] == sdrba_pkg::BL_CHOP;

    sdrba_pkg::sdrba_state_t state;
    logic [4:0] lat_cnt;
    logic [3:0] beat, beats;
    logic is_write, cur_ap;
    logic [2:0] cur_bank, cur_col;
    logic [15:0] cur_row, sel_row;
    logic [7:0] open_banks, busy_banks;
    logic col_go, last_beat, ap_go, strobe_bad, in_burst;
    logic [6:0] store_idx;
    logic [15:0] rd_data;
    sdrba_pkg::sdrba_bank_req_t bank_req;

    // only open banks start a burst
    assign col_go = col_cmd && state == sdrba_pkg::ST_IDLE && open_banks[cmd_bank];
    assign in_burst = state == sdrba_pkg::ST_BURST;
    assign last_beat = in_burst && beat == beats - 4'h1;
    assign ap_go = last_beat && cur_ap;
    // strobe expected high on even beats
    assign strobe_bad = in_burst && is_write && (dqs_s == beat[0]);
    assign store_idx = burst_idx(cur_bank, cur_row[0], cur_col, beat,
        beats == sdrba_pkg::COL_TO_COL_DELAY);

    always_comb begin
        bank_req.act = act_cmd;
        bank_req.pre = pre_cmd;
        bank_req.pre_all = cmd_addr[sdrba_pkg::AP_BIT];
        bank_req.bank = cmd_bank;
        bank_req.row = cmd_addr;
        bank_req.ap = ap_go;
        bank_req.ap_bank = cur_bank;
    end

    sdrba_bank_tracker u_banks (
        .clock(clock),
        .reset(reset),
        .req(bank_req),
        .sel_bank(cmd_bank),
        .sel_row(sel_row),
        .open_banks(open_banks),
        .busy_banks(busy_banks)
    );

    // bad data lands only at the addressed word
    sdrba_burst_store u_store (
        .clock(clock),
        .wr_en(in_burst && is_write),
        .idx(store_idx),
        .wr_data(dq_s),
        .rd_data(rd_data)
    );

    always_ff @(posedge clock) begin
        if (reset) begin
            state <= sdrba_pkg::ST_IDLE;
            lat_cnt <= 5'h00;
            beat <= 4'h0;
            beats <= sdrba_pkg::FULL_BEATS;
            is_write <= 1'b0;
            cur_ap <= 1'b0;
            cur_bank <= 3'h0;
            cur_col <= 3'h0;
            cur_row <= 16'h0000;
        end else begin
            case (state)
                sdrba_pkg::ST_IDLE: begin
                    if (col_go) begin
                        cur_col <= cmd_addr[2:0];
                        cur_bank <= cmd_bank;
                        cur_row <= sel_row;
                        cur_ap <= cmd_addr[sdrba_pkg::AP_BIT];
                        is_write <= wr_cmd;
                        beats <= cmd_chop ? sdrba_pkg::COL_TO_COL_DELAY : sdrba_pkg::FULL_BEATS;
                        lat_cnt <= rl - 5'h03;
                        beat <= 4'h0;
                        state <= sdrba_pkg::ST_LAT;
                    end
                end
                sdrba_pkg::ST_LAT: begin
                    if (lat_cnt == 5'h00) begin
                        state <= sdrba_pkg::ST_BURST;
                    end else begin
                        lat_cnt <= lat_cnt - 5'h01;
                    end
                end
                sdrba_pkg::ST_BURST: begin
                    // a burst always ends on its count, strobe or not
                    if (last_beat) begin
                        state <= sdrba_pkg::ST_IDLE;
                        beat <= 4'h0;
                    end else begin
                        beat <= beat + 4'h1;
                    end
                end
                default: state <= sdrba_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            dq_out <= 16'h0000;
            dq_oe_n <= 1'b1;
            dqs_out <= 1'b0;
            dqs_oe_n <= 1'b1;
        end else begin
            dq_oe_n <= !(in_burst && !is_write);
            dq_out <= (in_burst && !is_write) ? rd_data : 16'h0000;
            dqs_oe_n <= !(in_burst && !is_write && ctrl[sdrba_pkg::CTRL_DLL_BIT]);
            dqs_out <= in_burst && !is_write && !beat[0];
        end
    end

    always_comb begin
        err_set = '0;
        err_set[sdrba_pkg::ERR_ACT_OPEN] = act_cmd && open_banks[cmd_bank];
        err_set[sdrba_pkg::ERR_ACT_TRP] = act_cmd && busy_banks[cmd_bank];
        err_set[sdrba_pkg::ERR_COL_IDLE] = col_cmd && !open_banks[cmd_bank];
        err_set[sdrba_pkg::ERR_COL_BUSY] = col_cmd && state != sdrba_pkg::ST_IDLE;
        err_set[sdrba_pkg::ERR_STROBE] = strobe_bad;
    end

    logic wb_req, wb_wr;
    assign wb_req = wb_cyc_i && wb_stb_i;
    // Writes land at the edge where the master sees ack high.
    assign wb_wr = wb_req && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign err_clr = (wb_wr && wb_adr_i == sdrba_pkg::ADDR_ERROR) ?
        wb_dat_i[sdrba_pkg::ERR_BITS-1:0] : '0;

    always_ff @(posedge clock) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req && !wb_ack_o;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_ack_o) begin
            case (wb_adr_i)
                sdrba_pkg::ADDR_CTRL: wb_dat_o <= {24'h000000, ctrl};
                sdrba_pkg::ADDR_STATUS: wb_dat_o <= {14'h0000, is_write,
                    state != sdrba_pkg::ST_IDLE, busy_banks, open_banks};
                sdrba_pkg::ADDR_ERROR: wb_dat_o <= {27'h0000000, err};
                sdrba_pkg::ADDR_ROW: wb_dat_o <= {16'h0000, cur_row};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl <= sdrba_pkg::CTRL_RESET;
        end else if (wb_wr && wb_adr_i == sdrba_pkg::ADDR_CTRL) begin
            ctrl <= wb_dat_i[7:0];
        end
    end

    // A new event wins over a software clear in the same cycle.
    always_ff @(posedge clock) begin
        if (reset) begin
            err <= '0;
        end else begin
            err <= (err & ~err_clr) | err_set;
        end
    end

    logic [5:0] since_rd;
    logic [4:0] rd_rl;
    always_ff @(posedge clock) begin
        if (reset) begin
            since_rd <= 6'h00;
            rd_rl <= 5'h00;
        end else if (col_go && rd_cmd) begin
            since_rd <= 6'h01;
            rd_rl <= rl;
        end else if (since_rd != 6'h3F) begin
            since_rd <= since_rd + 6'h01;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    read_latency_a: assert property (
        $fell(dq_oe_n) |-> since_rd == {1'b0, rd_rl}) else $error("Read latency wrong.");
    chop_burst_a: assert property (
        $rose(in_burst) && beats == sdrba_pkg::COL_TO_COL_DELAY
        |-> in_burst [*4] ##1 !in_burst) else $error("Chopped burst not four beats.");
    full_burst_a: assert property (
        $rose(in_burst) && beats == sdrba_pkg::FULL_BEATS
        |-> in_burst [*8] ##1 !in_burst) else $error("Full burst not eight beats.");
    bl_mode_a: assert property (
        col_go && ctrl[1:0] == sdrba_pkg::BL_CHOP |=> beats == sdrba_pkg::COL_TO_COL_DELAY)
        else $error("Fixed chop code ignored.");
    col_addr_a: assert property (
        col_go |-> ##[2:40] (in_burst && beat == 4'h0 && store_idx[2:0] == $past(cur_col)))
        else $error("First beat not at column.");
    ap_close_a: assert property (
        ap_go |=> !open_banks[cur_bank] && busy_banks[cur_bank])
        else $error("Auto precharge did not close bank.");
    strobe_keep_a: assert property (
        strobe_bad && !last_beat |=> in_burst) else $error("Strobe fault stalled burst.");
    dqs_dll_a: assert property (
        !dqs_oe_n |-> $past(ctrl[sdrba_pkg::CTRL_DLL_BIT])) else $error("Strobe without loop.");
    col_idle_a: assert property (
        col_cmd && !open_banks[cmd_bank] |=> err[sdrba_pkg::ERR_COL_IDLE])
        else $error("Idle bank access not flagged.");
    act_trp_a: assert property (
        act_cmd && busy_banks[cmd_bank] |=> err[sdrba_pkg::ERR_ACT_TRP])
        else $error("Activate inside precharge period not flagged.");

    chop_read_c: cover property (col_go && rd_cmd && cmd_chop);
    full_write_ap_c: cover property (ap_go && is_write && beats == sdrba_pkg::FULL_BEATS);
    strobe_fault_c: cover property (strobe_bad);
    trp_refuse_c: cover property (act_cmd && busy_banks[cmd_bank]);
    al_read_c: cover property (col_go && rd_cmd && ctrl[sdrba_pkg::CTRL_AL_BIT]);
endmodule : sdrba_device
`default_nettype wire

// ### hw/sdrba_pkg.sv
// Constants, carrier types and contract of the SDRAM bank, row and burst block.
package sdrba_pkg;
    localparam int CLOCK_MHZ = 10;
    localparam int PRECHARGE_PERIOD_NS = 15;
    localparam logic [3:0] PRECHARGE_CYCLES =
        4'((PRECHARGE_PERIOD_NS * CLOCK_MHZ + 999) / 1000);
    localparam logic [3:0] FULL_BEATS = 4'h8;
    localparam logic [3:0] COL_TO_COL_DELAY = 4'h4;
    localparam logic [3:0] CL_MIN = 4'h5;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_ERROR = 8'h08;
    localparam logic [7:0] ADDR_ROW = 8'h0C;
    localparam int CTRL_CL_LSB = 2;
    localparam int CTRL_AL_BIT = 6;
    localparam int CTRL_DLL_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h94;
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_CHOP = 2'h2;
    localparam int ERR_ACT_OPEN = 0;
    localparam int ERR_ACT_TRP = 1;
    localparam int ERR_COL_IDLE = 2;
    localparam int ERR_COL_BUSY = 3;
    localparam int ERR_STROBE = 4;
    localparam int ERR_BITS = 5;
    localparam int AP_BIT = 10;
    localparam int BURST_SEL_BIT = 12;
    typedef enum logic [2:0] {
        CMD_PRE = 3'b010, CMD_ACT = 3'b011, CMD_WRITE = 3'b100, CMD_READ = 3'b101
    } sdrba_cmd_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_LAT = 2'b01, ST_BURST = 2'b10
    } sdrba_state_t;
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] bank_select_inputs;
        logic [15:0] row_address_inputs;
    } sdrba_pins_t;
    typedef struct packed {
        logic act;
        logic pre;
        logic pre_all;
        logic [2:0] bank;
        logic [15:0] row;
        logic ap;
        logic [2:0] ap_bank;
    } sdrba_bank_req_t;
endpackage : sdrba_pkg

// ### hw/sdrba_bank_tracker.sv
// Per-bank open row and precharge period tracking.
`timescale 1ns/1ns
`default_nettype none
module sdrba_bank_tracker (
    input wire logic clock,
    input wire logic reset,
    input wire sdrba_pkg::sdrba_bank_req_t req,
    input wire logic [2:0] sel_bank,
    output logic [15:0] sel_row,
    output logic [7:0] open_banks,
    output logic [7:0] busy_banks
);
    logic open_q [8];
    logic [15:0] row_q [8];
    logic [3:0] tmr_q [8];

    assign sel_row = row_q[sel_bank];

    for (genvar b = 0; b < 8; b++) begin : g_bank
        logic pre_hit;
        assign pre_hit = (req.pre && (req.pre_all || req.bank == 3'(b)))
            || (req.ap && req.ap_bank == 3'(b));
        assign open_banks[b] = open_q[b];
        assign busy_banks[b] = tmr_q[b] != 4'h0;
        always_ff @(posedge clock) begin
            if (reset) begin
                open_q[b] <= 1'b0;
                row_q[b] <= 16'h0000;
                tmr_q[b] <= 4'h0;
            end else if (pre_hit) begin
                open_q[b] <= 1'b0;
                tmr_q[b] <= sdrba_pkg::PRECHARGE_CYCLES;
            end else begin
                if (tmr_q[b] != 4'h0) begin
                    tmr_q[b] <= tmr_q[b] - 4'h1;
                end
                if (req.act && req.bank == 3'(b) && !open_q[b] && tmr_q[b] == 4'h0) begin
                    open_q[b] <= 1'b1;
                    row_q[b] <= req.row;
                end
            end
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    act_open_a: assert property (
        req.act && !open_banks[req.bank] && !busy_banks[req.bank] && !req.pre && !req.ap
        |=> open_banks[$past(req.bank)]) else $error("Activate did not open bank.");
    row_hold_a: assert property (
        !req.pre && !req.ap |=> (open_banks & $past(open_banks)) == $past(open_banks))
        else $error("Row closed without precharge.");
    pre_all_a: assert property (
        req.pre && req.pre_all |=> open_banks == 8'h00 && busy_banks == 8'hFF)
        else $error("Precharge all left a bank open.");
    pre_restart_a: assert property (
        req.pre && !req.pre_all && busy_banks[req.bank]
        |=> tmr_q[$past(req.bank)] == sdrba_pkg::PRECHARGE_CYCLES)
        else $error("Precharge period not restarted.");
    trp_block_a: assert property (
        req.act && busy_banks[req.bank] && !req.pre |=> !open_banks[$past(req.bank)])
        else $error("Activate accepted inside precharge period.");
endmodule : sdrba_bank_tracker
`default_nettype wire

// ### hw/sdrba_burst_store.sv
// Flip-flop storage for burst data words.
`timescale 1ns/1ns
`default_nettype none
module sdrba_burst_store (
    input wire logic clock,
    input wire logic wr_en,
    input wire logic [6:0] idx,
    input wire logic [15:0] wr_data,
    output logic [15:0] rd_data
);
    // No reset: like the array it stands for, contents are undefined until written.
    logic [15:0] mem [128];

    assign rd_data = mem[idx];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[idx] <= wr_data;
        end
    end
endmodule : sdrba_burst_store
`default_nettype wire

// ### tb/sdrba_ctrl_model.sv
// Controller-side model driving command pins, write data and write strobe.
`timescale 1ns/1ns
`default_nettype none
module sdrba_ctrl_model (
    input wire logic clock,
    output var sdrba_pkg::sdrba_pins_t cmd_pins,
    output logic [15:0] dq_in,
    output logic dqs_in,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe_n,
    input wire logic dqs_out,
    input wire logic dqs_oe_n
);
    int r_lat;
    logic [15:0] r_dat [8];
    logic [7:0] r_dqs;
    logic r_dqs_oe_n;
    logic r_end_oe_n;
    initial begin
        cmd_pins = '1;
        dq_in = 16'h0000;
        dqs_in = 1'b0;
    end
    task automatic issue(input sdrba_pkg::sdrba_cmd_t op, input logic [2:0] bank,
            input logic [15:0] addr);
        @(posedge clock);
        cmd_pins <= {1'b0, op, bank, addr};
        @(posedge clock);
        // The deselected bus shows inverted values, so a stale command can never look fresh.
        cmd_pins <= {1'b1, ~op, ~bank, ~addr};
    endtask : issue
    // two commands on consecutive cycles land inside the precharge period.
    task automatic issue_pair(input sdrba_pkg::sdrba_cmd_t op_a,
            input sdrba_pkg::sdrba_cmd_t op_b, input logic [2:0] bank,
            input logic [15:0] addr);
        @(posedge clock);
        cmd_pins <= {1'b0, op_a, bank, addr};
        @(posedge clock);
        cmd_pins <= {1'b0, op_b, bank, addr};
        @(posedge clock);
        cmd_pins <= {1'b1, ~op_b, ~bank, ~addr};
    endtask : issue_pair
    task automatic write_burst(input logic [2:0] bank, input logic [15:0] addr, input int n,
            input logic [15:0] base, input logic bad, input int rl);
        issue(sdrba_pkg::CMD_WRITE, bank, addr);
        repeat (rl - 2) @(posedge clock);
        for (int k = 0; k < n; k++) begin
            dq_in <= base + 16'(k);
            dqs_in <= 1'(k % 2 == 0) ^ bad;
            @(posedge clock);
        end
        dq_in <= ~dq_in;
        dqs_in <= ~dqs_in;
        repeat (4) @(posedge clock);
    endtask : write_burst
    task automatic read_burst(input logic [2:0] bank, input logic [15:0] addr, input int n);
        issue(sdrba_pkg::CMD_READ, bank, addr);
        r_lat = 1;
        r_dqs = 8'h00;
        @(negedge clock);
        while (dq_oe_n !== 1'b0 && r_lat < 40) begin
            @(negedge clock);
            r_lat++;
        end
        r_dqs_oe_n = dqs_oe_n;
        for (int k = 0; k < n; k++) begin
            r_dat[k] = dq_out;
            r_dqs[k] = dqs_out;
            @(negedge clock);
        end
        r_end_oe_n = dq_oe_n;
        repeat (3) @(posedge clock);
    endtask : read_burst
endmodule : sdrba_ctrl_model
`default_nettype wire

// ### tb/sdrba_device_tb.sv
// Self-checking bench for the bank, row and burst access block.
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module sdrba_device_tb;
    logic clock, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic dq_oe_n, dqs_out, dqs_oe_n, dqs_in;
    logic [15:0] dq_in, dq_out;
    sdrba_pkg::sdrba_pins_t cmd_pins;
    logic [15:0] mem [8];
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    sdrba_device sdrba_device_i (.clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmd_pins(cmd_pins),
        .dq_in(dq_in), .dqs_in(dqs_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n));
    sdrba_ctrl_model sdrba_ctrl_model_i (.clock(clock), .cmd_pins(cmd_pins), .dq_in(dq_in),
        .dqs_in(dqs_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dqs_out(dqs_out),
        .dqs_oe_n(dqs_oe_n));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (failures == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'hF;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50)
            failures++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task automatic cmd(input sdrba_pkg::sdrba_cmd_t c, input logic [2:0] b, input logic [15:0] a);
        sdrba_ctrl_model_i.issue(c, b, a);
        repeat (4) @(posedge clock);
    endtask : cmd
    // Chopped bursts wrap inside the aligned group of four columns.
    function automatic logic [2:0] widx(input logic [2:0] col, input int k, input int n);
        return (n == 8) ? col + 3'(k) : {col[2], col[1:0] + 2'(k)};
    endfunction : widx
    task automatic wr(input logic [2:0] col, input int n, input logic [15:0] base, input logic bad);
        sdrba_ctrl_model_i.write_burst(3'h3, {3'h0, 1'(n == 8), 9'h000, col}, n, base, bad, 5);
        for (int k = 0; k < n; k++)
            mem[widx(col, k, n)] = base + 16'(k);
    endtask : wr
    task automatic rd(input logic [2:0] col, input logic a12, input int n, input int rl,
            input logic dll);
        sdrba_ctrl_model_i.read_burst(3'h3, {3'h0, a12, 9'h000, col}, n);
        `CHK(sdrba_ctrl_model_i.r_lat, rl + 2)
        `CHK(sdrba_ctrl_model_i.r_end_oe_n, 1'b1)
        `CHK(sdrba_ctrl_model_i.r_dqs_oe_n, ~dll)
        if (dll)
            `CHK(sdrba_ctrl_model_i.r_dqs, n == 8 ? 8'h55 : 8'h05)
        for (int k = 0; k < n; k++)
            `CHK(sdrba_ctrl_model_i.r_dat[k], mem[widx(col, k, n)])
    endtask : rd
    initial begin
        reset = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h00000000;
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        `CHK({dq_oe_n, dqs_oe_n, wb_ack_o}, 3'b110)
        wb(1'b0, 8'h00, 32'h0);
        `CHK(q, 32'h00000094)
        cmd(sdrba_pkg::CMD_ACT, 3'h3, 16'h0001);
        wb(1'b0, 8'h04, 32'h0);
        `CHK(q[7:0], 8'h08)
        cmd(sdrba_pkg::CMD_ACT, 3'h3, 16'h0002);
        wb(1'b0, 8'h08, 32'h0);
        `CHK(q[4:0], 5'h01)
        wb(1'b1, 8'h08, 32'h1F);
        wr(3'h0, 8, 16'hA000, 1'b0);
        rd(3'h0, 1'b1, 8, 5, 1'b1);
        wb(1'b0, 8'h0C, 32'h0);
        `CHK(q[15:0], 16'h0001)
        for (int c = 0; c < 4; c++) begin
            wb(1'b1, 8'h00, 32'h94 | 32'(c));
            for (int a = 0; a < 2; a++)
                rd(3'h5, 1'(a), c[1] ? (c[0] ? 8 : 4) : (a ? 8 : 4), 5, 1'b1);
        end
        wb(1'b1, 8'h00, 32'h000000D4);
        rd(3'h0, 1'b1, 8, 9, 1'b1);
        wb(1'b1, 8'h00, 32'h00000014);
        rd(3'h1, 1'b0, 4, 5, 1'b0);
        wb(1'b1, 8'h00, 32'h00000094);
        wr(3'h0, 4, 16'hB000, 1'b1);
        wb(1'b0, 8'h08, 32'h0);
        `CHK(q[4:0], 5'h10)
        wb(1'b1, 8'h08, 32'h1F);
        rd(3'h0, 1'b1, 8, 5, 1'b1);
        cmd(sdrba_pkg::CMD_READ, 3'h5, 16'h0000);
        wb(1'b0, 8'h08, 32'h0);
        `CHK(q[4:0], 5'h04)
        wb(1'b1, 8'h08, 32'h1F);
        cmd(sdrba_pkg::CMD_PRE, 3'h3, 16'h0000);
        wb(1'b0, 8'h04, 32'h0);
        `CHK(q[7:0], 8'h00)
        cmd(sdrba_pkg::CMD_PRE, 3'h3, 16'h0000);
        cmd(sdrba_pkg::CMD_ACT, 3'h3, 16'h0001);
        cmd(sdrba_pkg::CMD_ACT, 3'h2, 16'h0000);
        sdrba_ctrl_model_i.read_burst(3'h2, 16'h0400, 4);
        wb(1'b0, 8'h04, 32'h0);
        `CHK(q[7:0], 8'h08)
        wb(1'b0, 8'h08, 32'h0);
        `CHK(q[4:0], 5'h00)
        sdrba_ctrl_model_i.issue_pair(sdrba_pkg::CMD_PRE, sdrba_pkg::CMD_PRE, 3'h1, 16'h0000);
        sdrba_ctrl_model_i.issue_pair(sdrba_pkg::CMD_PRE, sdrba_pkg::CMD_ACT, 3'h3, 16'h0001);
        repeat (4) @(posedge clock);
        wb(1'b0, 8'h08, 32'h0);
        `CHK(q[4:0], 5'h02)
        wb(1'b0, 8'h04, 32'h0);
        `CHK(q[7:0], 8'h00)
        cmd(sdrba_pkg::CMD_ACT, 3'h1, 16'h0000);
        cmd(sdrba_pkg::CMD_PRE, 3'h0, 16'h0400);
        wb(1'b0, 8'h04, 32'h0);
        `CHK(q[7:0], 8'h00)
        wb(1'b1, 8'h10, 32'hFF);
        wb(1'b0, 8'h10, 32'h0);
        `CHK(q, 32'h00000000)
        wb(1'b1, 8'h00, 32'h00000017);
        cmd(sdrba_pkg::CMD_ACT, 3'h1, 16'h0000);
        // a full reset after a control write and an activate restores the start state.
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        `CHK({dq_oe_n, dqs_oe_n, wb_ack_o}, 3'b110)
        wb(1'b0, 8'h00, 32'h0);
        `CHK(q, 32'h00000094)
        wb(1'b0, 8'h04, 32'h0);
        `CHK(q[17:0], 18'h00000)
        wb(1'b0, 8'h08, 32'h0);
        `CHK(q[4:0], 5'h00)
        report_and_stop();
    end
endmodule : sdrba_device_tb
`default_nettype wire
